// *** core/ufp_port.sv ***
`timescale 1ns/100ps
module ufp_port #(
	parameter int ADDR_W     = 9,
	parameter int DATA_W     = 16,
	parameter bit READ_WRITE = 1'b1
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              read_request_low_i,
	input  wire logic              write_request_low_i,
	input  wire logic              erase_request_low_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] write_word_in_i,
	output logic                   operation_pending_low_o,
	output logic                   read_valid_o,
	output logic [DATA_W-1:0]      read_word_o,
	output logic                   oscillator_enable_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_BUSY, ST_RELEASE} ufp_state_t;

	// Buses narrower than 3 bits or wider than the array cannot be padded
	if (ADDR_W < 3 || ADDR_W > ufp_pkg::FULL_ADDR_W || DATA_W < 3 ||
		DATA_W > ufp_pkg::FULL_DATA_W)
	begin : width_check
		$error("ufp_port: address width 3..9 and data width 3..16 only");
	end

	logic [2:0]  req_m_q, req_s_q, req_p_q;
	logic [ADDR_W-1:0] addr_m_q, addr_s_q;
	logic [DATA_W-1:0] wd_m_q, wd_s_q;
	ufp_state_t  st_q;
	logic [7:0]  cnt_q;
	logic [1:0]  op_q;
	logic        pend_q;
	logic        start;
	logic        done;
	logic [8:0]  full_addr;
	logic [15:0] full_wdata;
	logic [15:0] rdata;
	logic [2:0]  fall;
	logic        one_fall;

	// Two-flop synchronisers; pins arrive from outside the clock domain
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_m_q <= 3'h7;
			req_s_q <= 3'h7;
			req_p_q <= 3'h7;
		end
		else
		begin
			req_m_q <= {erase_request_low_i, write_request_low_i, read_request_low_i};
			req_s_q <= req_m_q;
			req_p_q <= req_s_q;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		addr_m_q <= addr_i;
		addr_s_q <= addr_m_q;
		wd_m_q   <= write_word_in_i;
		wd_s_q   <= wd_m_q;
	end

	assign fall     = req_p_q & ~req_s_q;
	// Exactly one line low; any other pattern is dropped without effect
	assign one_fall = (fall != 3'h0) && ($countones(~req_s_q) == 1);
	assign oscillator_enable_o = READ_WRITE;

	// Short location bus pads low bits with zero, short data pads with ones
	assign full_addr  = 9'({addr_s_q, (ufp_pkg::FULL_ADDR_W - ADDR_W + 1)'(0)} >> 1);
	assign full_wdata = 16'({wd_s_q, {(ufp_pkg::FULL_DATA_W - DATA_W + 1){1'b1}}} >> 1);

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_q   <= ST_IDLE;
			cnt_q  <= 8'h00;
			op_q   <= ufp_pkg::OP_READ;
			pend_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					// Write or erase in a read-only build is refused silently
					if (one_fall && (READ_WRITE || !req_s_q[0] == 1'b1))
					begin
						op_q   <= !req_s_q[0] ? ufp_pkg::OP_READ :
							(!req_s_q[1] ? ufp_pkg::OP_WRITE : ufp_pkg::OP_ERASE);
						pend_q <= 1'b1;
						cnt_q  <= 8'(ufp_pkg::SAMPLE_CYC);
						st_q   <= ST_SAMPLE;
					end
				end
				ST_SAMPLE:
				begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01)
						st_q <= ST_BUSY;
				end
				ST_BUSY:
				begin
					if (done)
						st_q <= ST_RELEASE;
				end
				default:
				begin
					// Wait for the request line to rise so one pulse is one operation
					if (req_s_q == 3'h7)
					begin
						pend_q <= 1'b0;
						st_q   <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign start = (st_q == ST_SAMPLE) && (cnt_q == 8'h01);
	assign operation_pending_low_o = ~pend_q;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			read_valid_o <= 1'b0;
			read_word_o  <= '0;
		end
		else if (start)
			read_valid_o <= 1'b0;
		else if (done && op_q == ufp_pkg::OP_READ)
		begin
			read_valid_o <= 1'b1;
			read_word_o  <= rdata[ufp_pkg::FULL_DATA_W-1 -: DATA_W];
		end
	end

	ufp_array u_array (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.osc_en_i  (oscillator_enable_o),
		.start_i   (start),
		.op_i      (op_q),
		.addr_i    (full_addr),
		.wdata_i   (full_wdata),
		.done_o    (done),
		.rdata_o   (rdata)
	);

	// Timer from the synced request fall, read only by the pending-bound check
	logic [5:0] wait_q;
	logic       solo_q;
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wait_q <= 6'h00;
			solo_q <= 1'b0;
		end
		else if (fall != 3'h0 && st_q == ST_IDLE)
		begin
			wait_q <= 6'h01;
			// A lone request that this build serves must bring pending down in time
			solo_q <= ($countones(~req_s_q) == 1) && (READ_WRITE || req_s_q[2:1] == 2'h3);
		end
		else if (wait_q != 6'h00 && wait_q != 6'h3f)
			wait_q <= wait_q + 6'h01;
	end

	pend_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q == ST_IDLE && one_fall && !req_s_q[0]) |=> !operation_pending_low_o)
		else $error("pending did not fall after a read request");
	pend_bound_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(wait_q == 6'(ufp_pkg::PEND_MAX_CYC - 3) && solo_q) |-> !operation_pending_low_o)
		else $error("pending late");
	multi_ignore_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q == ST_IDLE && $countones(~req_s_q) > 1) |=> st_q == ST_IDLE)
		else $error("multiple requests accepted");
	pend_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q == ST_BUSY) |-> !operation_pending_low_o)
		else $error("pending high during operation");
	pend_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q == ST_RELEASE && req_s_q == 3'h7) |=> operation_pending_low_o)
		else $error("pending not released");
	read_valid_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(done && op_q == ufp_pkg::OP_READ) |=> read_valid_o)
		else $error("read valid missing after read");
	valid_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		start |=> !read_valid_o)
		else $error("read valid held over new operation");
	osc_build_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		oscillator_enable_o == READ_WRITE)
		else $error("oscillator enable wrong for build");
	ro_refuse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!READ_WRITE && st_q == ST_IDLE && req_s_q[0]) |=> st_q == ST_IDLE)
		else $error("read-only build accepted write or erase");
endmodule : ufp_port

// *** core/ufp_pkg.sv ***
// Overview of operation
// - Read, write and erase requests are active low, asserted at zero and idle at one.
// - The pending flag goes low within 300 ns of the falling edge of an accepted request.
// - The location bus is up to 9 bits and the data bus up to 16 bits, set at build time.
// - The port is built either for read/write or for read-only access to the array.
// - In a read/write build the array oscillator runs continuously.
// - In a read-only build the array oscillator is kept disabled.
// - Pending stays low through the whole operation and returns high once it completes and all request lines are high again.
// - After a read completes, read-valid goes high and the read word holds the last location.
// - Two or more simultaneous requests are all ignored and nothing is done.
// - Erase clears a whole sector chosen by the top bit of the full 9-bit location.
package ufp_pkg;
	localparam int          FULL_ADDR_W    = 9;
	localparam int          FULL_DATA_W    = 16;
	localparam int          SECTOR_BIT     = FULL_ADDR_W - 1;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          T_CMD_MIN_NS   = 600;
	localparam int          T_PEND_MAX_NS  = 300;
	localparam int          T_HOLD_NS      = 600;
	// Sample the bus a little before the requester may release it
	localparam int          SAMPLE_CYC     = T_HOLD_NS / CLK_PERIOD_NS - 10;
	localparam int          PEND_MAX_CYC   = T_PEND_MAX_NS / CLK_PERIOD_NS;
	localparam int          READ_CYC       = 8;
	localparam int          WRITE_CYC      = 64;
	localparam int          ERASE_CYC      = 512;
	localparam logic [15:0] ERASED_WORD    = 16'hffff;
	localparam logic [1:0]  OP_READ        = 2'h0;
	localparam logic [1:0]  OP_WRITE       = 2'h1;
	localparam logic [1:0]  OP_ERASE       = 2'h2;
endpackage : ufp_pkg

// *** core/ufp_array.sv ***
`timescale 1ns/100ps
// Flip-flop model of the flash array: busy timing driven by the oscillator enable
module ufp_array (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        osc_en_i,
	input  wire logic        start_i,
	input  wire logic [1:0]  op_i,
	input  wire logic [8:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	output logic             done_o,
	output logic [15:0]      rdata_o
);
	localparam int WORDS = 1 << ufp_pkg::FULL_ADDR_W;
	localparam int HALF  = WORDS / 2;

	logic [15:0] mem_q [WORDS];
	logic [9:0]  cnt_q;
	logic        run_q;

	function automatic logic [9:0] op_len(input logic [1:0] op);
		if (op == ufp_pkg::OP_READ)
			return 10'(ufp_pkg::READ_CYC);
		else if (op == ufp_pkg::OP_WRITE)
			return 10'(ufp_pkg::WRITE_CYC);
		else
			return 10'(ufp_pkg::ERASE_CYC);
	endfunction : op_len

	// Timer loads the full op length while the oscillator runs, else one cycle; reads are registered at start
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_q  <= 1'b0;
			cnt_q  <= 10'h000;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i && !run_q)
			begin
				run_q <= 1'b1;
				cnt_q <= osc_en_i ? op_len(op_i) : 10'h001;
			end
			else if (run_q)
			begin
				cnt_q <= cnt_q - 10'h001;
				if (cnt_q == 10'h001)
				begin
					run_q  <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (start_i && !run_q)
		begin
			if (op_i == ufp_pkg::OP_READ)
				rdata_o <= mem_q[addr_i];
			else if (op_i == ufp_pkg::OP_WRITE)
				mem_q[addr_i] <= mem_q[addr_i] & wdata_i;
			else
				for (int i = 0; i < HALF; i++)
					mem_q[{addr_i[ufp_pkg::SECTOR_BIT], 8'(i)}] <= ufp_pkg::ERASED_WORD;
		end
	end
endmodule : ufp_array

// *** bench/ufp_requester.sv ***
`timescale 1ns/100ps
module ufp_requester #(
	parameter int HOLD_CYC = 80
) (
	input  wire logic   clk_sys_i,
	output logic        read_request_low_o,
	output logic        write_request_low_o,
	output logic        erase_request_low_o,
	output logic [8:0]  addr_o,
	output logic [15:0] write_word_o
);
	initial
	begin
		{read_request_low_o, write_request_low_o, erase_request_low_o} = 3'h7;
		addr_o = 9'h0;
		write_word_o = 16'h0;
	end

	// 800 ns low sits well inside the legal request window
	task automatic issue(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
		input logic two);
		@(posedge clk_sys_i);
		#1;
		addr_o = a;
		write_word_o = d;
		read_request_low_o = !(op == ufp_pkg::OP_READ || two);
		write_request_low_o = !(op == ufp_pkg::OP_WRITE);
		erase_request_low_o = !(op == ufp_pkg::OP_ERASE);
		repeat (HOLD_CYC) @(posedge clk_sys_i);
		#1;
		{read_request_low_o, write_request_low_o, erase_request_low_o} = 3'h7;
		// A released bus must not look like the word just sampled
		addr_o = ~addr_o;
		write_word_o = ~write_word_o;
	endtask : issue
endmodule : ufp_requester

// *** bench/tb_user_flash_parallel_port.sv ***
`timescale 1ns/100ps
module tb_user_flash_parallel_port;
	logic        clk_sys_i;
	logic        rst_i;
	logic        rd_low, wr_low, er_low, pend_low, valid, osc, osc_ro, pend_ro;
	logic [8:0]  addr;
	logic [15:0] wdata, rword;
	logic [15:0] mem [512];
	logic [31:0] seed = 32'h28e0;
	logic [31:0] r;
	int          fails = 0;
	int          checked = 0;

	ufp_requester ufp_requester_i (.clk_sys_i(clk_sys_i), .read_request_low_o(rd_low),
		.write_request_low_o(wr_low), .erase_request_low_o(er_low), .addr_o(addr),
		.write_word_o(wdata));
	ufp_port #(.READ_WRITE(1'b1)) ufp_port_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.read_request_low_i(rd_low), .write_request_low_i(wr_low),
		.erase_request_low_i(er_low), .addr_i(addr), .write_word_in_i(wdata),
		.operation_pending_low_o(pend_low), .read_valid_o(valid), .read_word_o(rword),
		.oscillator_enable_o(osc));
	ufp_port #(.READ_WRITE(1'b0)) ufp_port_ro_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.read_request_low_i(rd_low), .write_request_low_i(wr_low),
		.erase_request_low_i(er_low), .addr_i(addr), .write_word_in_i(wdata),
		.operation_pending_low_o(pend_ro), .read_valid_o(), .read_word_o(),
		.oscillator_enable_o(osc_ro));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : check

	task automatic wrap_up();
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic run_op(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
		input logic two);
		int n;
		n = 0;
		fork
			ufp_requester_i.issue(op, a, d, two);
			begin
				// Look just after the requester has driven its lines
				@(posedge clk_sys_i);
				#2;
				while (pend_low === 1'b1 && n < 60)
				begin
					@(posedge clk_sys_i);
					#1;
					n++;
				end
			end
		join
		check("ro pending", op != ufp_pkg::OP_READ || two, pend_ro);
		if (two)
			check("refused pending", 1'b1, pend_low);
		else
		begin
			check("pending delay", 1'b1, n <= ufp_pkg::PEND_MAX_CYC);
			check("pending held", 1'b0, pend_low);
		end
		n = 0;
		while (pend_low !== 1'b1 && n < 2000)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check("pending release", 1'b1, pend_low);
		if (n == 2000)
			wrap_up();
		if (!two && op == ufp_pkg::OP_ERASE)
		begin
			check("erase length", 1'b1, n + 80 >= ufp_pkg::ERASE_CYC);
			for (int k = 0; k < 256; k++)
				mem[{a[8], k[7:0]}] = ufp_pkg::ERASED_WORD;
		end
		if (!two && op == ufp_pkg::OP_WRITE)
			mem[a] = mem[a] & d;
		if (!two && op == ufp_pkg::OP_READ)
		begin
			check("read valid", 1'b1, valid);
			check("read word", mem[a], rword);
		end
	endtask : run_op

	initial
	begin
		rst_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		check("rw oscillator", 1'b1, osc);
		check("ro oscillator", 1'b0, osc_ro);
		run_op(ufp_pkg::OP_ERASE, 9'h000, 16'h0, 1'b0);
		run_op(ufp_pkg::OP_ERASE, 9'h1ff, 16'h0, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			r = xorshift();
			run_op(ufp_pkg::OP_WRITE, r[8:0], r[31:16], 1'b0);
			run_op(ufp_pkg::OP_READ, r[8:0], 16'h0, 1'b0);
		end
		run_op(ufp_pkg::OP_WRITE, 9'h005, 16'h1234, 1'b0);
		run_op(ufp_pkg::OP_WRITE, 9'h005, 16'h0, 1'b1);
		run_op(ufp_pkg::OP_ERASE, 9'h1aa, 16'h0, 1'b0);
		run_op(ufp_pkg::OP_READ, 9'h005, 16'h0, 1'b0);
		run_op(ufp_pkg::OP_READ, 9'h1ff, 16'h0, 1'b0);
		run_op(ufp_pkg::OP_READ, 9'h0ff, 16'h0, 1'b0);
		wrap_up();
	end
endmodule : tb_user_flash_parallel_port
